// >>> src/vcp_regs.sv
// Purpose: capture port control registers and the small logic they steer
// Assumes: index/data strobes and memory events are synchronous to clk
// Notes:   vsync and href pins are asynchronous and synchronised here
`default_nettype none
////////////////////////////////////////////////////////////////////////
module vcp_regs (
  // clock and reset
  input  wire  logic                         clk,
  input  wire  logic                         rstn,
  input  wire  logic                         clk_en,
  // indexed register port
  input  wire  logic [7:0]                   io_idx,
  input  wire  logic                         io_wr,
  input  wire  logic                         io_rd,
  input  wire  logic [7:0]                   io_wdata,
  output var   logic [7:0]                   io_rdata_q,
  // neighbouring state
  input  wire  logic [vcp_pkg::ADDR_LO_W-1:0] start_addr_low,
  input  wire  logic                         sequencer_ext_config,
  input  wire  logic                         odd_even_invert,
  // port pins
  input  wire  logic                         port_vsync,
  input  wire  logic                         port_href,
  output var   logic                         capture_sync_control_pin_q,
  output var   logic                         capture_sync_control_pin_oe_q,
  // memory scheduler
  input  wire  vcp_pkg::vcp_mem_evt_t        mem_evt,
  output var   vcp_pkg::vcp_burst_t          port_burst_q,
  output var   vcp_pkg::vcp_limit_t          win_end_limit_q,
  output var   logic [vcp_pkg::GFX_THR_W-1:0] gfx_cas_per_cycle_q,
  output var   logic [vcp_pkg::ADDR_W-1:0]   active_addr_q,
  output var   logic                         field_capture_q,
  // overlay window pixels
  input  wire  vcp_pkg::vcp_pix_t            pix_in,
  output var   vcp_pkg::vcp_pix_t            pix_out_q
);
  ////////////////////////////////////////////////////////////////////////
  // index decode, shared by read and write
  function automatic logic [2:0] decode(input logic [7:0] idx);
    unique case (idx)
      vcp_pkg::IDX_ADDR_HI:  decode = {1'b1, vcp_pkg::SLOT_ADDR_HI};
      vcp_pkg::IDX_CYC_CTL:  decode = {1'b1, vcp_pkg::SLOT_CYC_CTL};
      vcp_pkg::IDX_LUMA_OFS: decode = {1'b1, vcp_pkg::SLOT_LUMA_OFS};
      vcp_pkg::IDX_PIN_CTL:  decode = {1'b1, vcp_pkg::SLOT_PIN_CTL};
      default:               decode = 3'h0;
    endcase
  endfunction

  logic [7:0]  regs_q [vcp_pkg::NUM_REGS];
  logic [7:0]  regs_d [vcp_pkg::NUM_REGS];
  logic [1:0]  field_cnt_q, field_cnt_d;
  logic        vs_s1_q, vs_s2_q, vs_s3_q;
  logic        hr_s1_q, hr_s2_q;
  logic        vs_fall;
  logic [2:0]  wr_dec, rd_dec;
  logic [7:0]  rdata_d;
  logic [vcp_pkg::ADDR_W-1:0] addr_d;
  logic        pin_d, pin_oe_d, field_d;
  vcp_pkg::vcp_burst_t burst_d;
  vcp_pkg::vcp_limit_t limit_d;
  vcp_pkg::vcp_pix_t   pix_d;
  logic signed [9:0]   luma_sum;

  ////////////////////////////////////////////////////////////////////////
  // pin synchronisers; first stage feeds only the second
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      vs_s1_q <= 1'b0;
      vs_s2_q <= 1'b0;
      vs_s3_q <= 1'b0;
      hr_s1_q <= 1'b0;
      hr_s2_q <= 1'b0;
    end else if (clk_en) begin
      vs_s1_q <= port_vsync;
      vs_s2_q <= vs_s1_q;
      vs_s3_q <= vs_s2_q;
      hr_s1_q <= port_href;
      hr_s2_q <= hr_s1_q;
    end
  end

  assign vs_fall = vs_s3_q & ~vs_s2_q;
  assign wr_dec  = decode(io_idx);
  assign rd_dec  = decode(io_idx);

  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    for (int i = 0; i < vcp_pkg::NUM_REGS; i++) begin
      regs_d[i] = regs_q[i];
    end
    field_cnt_d = field_cnt_q;
    rdata_d     = io_rdata_q;
    addr_d      = active_addr_q;
    pin_d       = capture_sync_control_pin_q;
    field_d     = field_capture_q;
    pin_oe_d    = ~sequencer_ext_config;
    burst_d     = '0;
    limit_d     = '0;

    if (io_rd && rd_dec[2]) begin
      rdata_d = regs_q[rd_dec[1:0]];
      // reading the status clears it; an underrun in the same cycle still lands below
      if (rd_dec[1:0] == vcp_pkg::SLOT_CYC_CTL) begin
        regs_d[vcp_pkg::SLOT_CYC_CTL][vcp_pkg::UNDERRUN_BIT] = 1'b0;
      end
    end

    if (io_wr && wr_dec[2]) begin
      if (wr_dec[1:0] == vcp_pkg::SLOT_CYC_CTL) begin
        // status bit is read-only
        regs_d[wr_dec[1:0]] = {io_wdata[7:4], regs_d[wr_dec[1:0]][vcp_pkg::UNDERRUN_BIT], io_wdata[2:0]};
      end else begin
        regs_d[wr_dec[1:0]] = io_wdata;
      end
      if (wr_dec[1:0] == vcp_pkg::SLOT_PIN_CTL && io_wdata[vcp_pkg::TWO_FIELD_BIT]) begin
        field_cnt_d = 2'h0;
      end
    end

    if (mem_evt.underrun) begin
      regs_d[vcp_pkg::SLOT_CYC_CTL][vcp_pkg::UNDERRUN_BIT] = 1'b1;
    end

    if (vs_fall) begin
      addr_d = {regs_q[vcp_pkg::SLOT_ADDR_HI], start_addr_low};
      if (!sequencer_ext_config) begin
        pin_d = regs_q[vcp_pkg::SLOT_PIN_CTL][vcp_pkg::PIN_OUT_BIT];
      end
      // odd field: vsync falls while href is high, meaning flipped by invert
      field_d = ~regs_q[vcp_pkg::SLOT_PIN_CTL][vcp_pkg::ODD_ONLY_BIT]
                | (hr_s2_q ^ odd_even_invert);
      if (regs_d[vcp_pkg::SLOT_PIN_CTL][vcp_pkg::TWO_FIELD_BIT]) begin
        // first edge opens the first full field, the third closes the second
        field_cnt_d = field_cnt_q + 2'h1;
        if (field_cnt_d == vcp_pkg::TWO_FIELD_EDGES) begin
          regs_d[vcp_pkg::SLOT_PIN_CTL][vcp_pkg::TWO_FIELD_BIT] = 1'b0;
          field_d     = 1'b0;
          field_cnt_d = 2'h0;
        end
      end
    end

    // window fifo miss takes priority when both arrive together
    if (mem_evt.vw_miss) begin
      burst_d.len   = regs_q[vcp_pkg::SLOT_CYC_CTL][vcp_pkg::VW_MISS_LSB +: vcp_pkg::MISS_W];
      burst_d.valid = burst_d.len != vcp_pkg::MISS_SKIP;
    end else if (mem_evt.crt_miss) begin
      burst_d.len   = regs_q[vcp_pkg::SLOT_CYC_CTL][vcp_pkg::CRT_MISS_LSB +: vcp_pkg::MISS_W];
      burst_d.valid = burst_d.len != vcp_pkg::MISS_SKIP;
    end

    if (mem_evt.win_end && regs_q[vcp_pkg::SLOT_PIN_CTL][vcp_pkg::RS_EN_BIT]) begin
      limit_d.valid = 1'b1;
      limit_d.total = regs_q[vcp_pkg::SLOT_PIN_CTL][vcp_pkg::RS_THR_LSB +: vcp_pkg::RS_THR_W];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // luma offset, clamped so a large offset cannot wrap black to white
  always_comb begin
    pix_d    = pix_in;
    luma_sum = $signed({2'b00, pix_in.luma}) + 10'($signed(regs_q[vcp_pkg::SLOT_LUMA_OFS]));
    if (pix_in.in_win) begin
      if (luma_sum < 0) begin
        pix_d.luma = 8'h00;
      end else if (luma_sum > $signed({2'b00, vcp_pkg::LUMA_MAX})) begin
        pix_d.luma = vcp_pkg::LUMA_MAX;
      end else begin
        pix_d.luma = luma_sum[7:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < vcp_pkg::NUM_REGS; i++) begin
        regs_q[i] <= vcp_pkg::REG_RESET;
      end
      field_cnt_q                   <= 2'h0;
      io_rdata_q                    <= 8'h00;
      active_addr_q                 <= '0;
      capture_sync_control_pin_q    <= 1'b0;
      capture_sync_control_pin_oe_q <= 1'b0;
      field_capture_q               <= 1'b1;
      port_burst_q                  <= '0;
      win_end_limit_q               <= '0;
      gfx_cas_per_cycle_q           <= '0;
      pix_out_q                     <= '0;
    end else if (clk_en) begin
      for (int i = 0; i < vcp_pkg::NUM_REGS; i++) begin
        regs_q[i] <= regs_d[i];
      end
      field_cnt_q                   <= field_cnt_d;
      io_rdata_q                    <= rdata_d;
      active_addr_q                 <= addr_d;
      capture_sync_control_pin_q    <= pin_d;
      capture_sync_control_pin_oe_q <= pin_oe_d;
      field_capture_q               <= field_d;
      port_burst_q                  <= burst_d;
      win_end_limit_q               <= limit_d;
      gfx_cas_per_cycle_q           <= regs_q[vcp_pkg::SLOT_CYC_CTL][vcp_pkg::GFX_THR_LSB +: vcp_pkg::GFX_THR_W];
      pix_out_q                     <= pix_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  logic [7:0] cyc_reg, pin_reg;
  assign cyc_reg = regs_q[vcp_pkg::SLOT_CYC_CTL];
  assign pin_reg = regs_q[vcp_pkg::SLOT_PIN_CTL];

  underrun_set_a: assert property (clk_en && mem_evt.underrun |=> cyc_reg[vcp_pkg::UNDERRUN_BIT])
    else $error("underrun not flagged");
  read_clears_a: assert property (clk_en && io_rd && io_idx == vcp_pkg::IDX_CYC_CTL && !mem_evt.underrun
    |=> !cyc_reg[vcp_pkg::UNDERRUN_BIT])
    else $error("underrun not cleared by read");
  addr_hold_a: assert property (!(clk_en && vs_fall) |=> $stable(active_addr_q))
    else $error("active address moved outside retrace");
  addr_load_a: assert property (clk_en && vs_fall
    |=> active_addr_q == {$past(regs_q[vcp_pkg::SLOT_ADDR_HI]), $past(start_addr_low)})
    else $error("active address not loaded whole");
  vw_burst_a: assert property (clk_en && mem_evt.vw_miss
    |=> port_burst_q.len == $past(cyc_reg[7:6]) && port_burst_q.valid == ($past(cyc_reg[7:6]) != 2'h0))
    else $error("window miss burst wrong");
  crt_burst_a: assert property (clk_en && mem_evt.crt_miss && !mem_evt.vw_miss
    |=> port_burst_q.len == $past(cyc_reg[5:4]) && port_burst_q.valid == ($past(cyc_reg[5:4]) != 2'h0))
    else $error("crt miss burst wrong");
  pin_stable_a: assert property (!(clk_en && vs_fall) |=> $stable(capture_sync_control_pin_q))
    else $error("sync pin changed off the vsync edge");
  pin_value_a: assert property (clk_en && vs_fall && !sequencer_ext_config
    |=> capture_sync_control_pin_q == $past(pin_reg[vcp_pkg::PIN_OUT_BIT]))
    else $error("sync pin value wrong");
  limit_out_a: assert property (clk_en && mem_evt.win_end && pin_reg[vcp_pkg::RS_EN_BIT]
    |=> win_end_limit_q.valid && win_end_limit_q.total == $past(pin_reg[3:0]))
    else $error("window end limit wrong");
  gfx_thr_a: assert property (clk_en ##1 clk_en |-> gfx_cas_per_cycle_q == $past(cyc_reg[2:0]))
    else $error("graphics threshold not followed");
  luma_zero_a: assert property (clk_en && pix_in.in_win && regs_q[vcp_pkg::SLOT_LUMA_OFS] == 8'h00
    |=> pix_out_q.luma == $past(pix_in.luma))
    else $error("zero offset changed luma");

  miss_burst_c: cover property (clk_en && mem_evt.vw_miss ##1 port_burst_q.valid && port_burst_q.len == 2'h3);
  two_field_c: cover property ($fell(pin_reg[vcp_pkg::TWO_FIELD_BIT]));
  underrun_read_c: cover property (cyc_reg[vcp_pkg::UNDERRUN_BIT] ##1 !cyc_reg[vcp_pkg::UNDERRUN_BIT]);
endmodule : vcp_regs
`default_nettype wire

// >>> src/vcp_pkg.sv
// Purpose: constants and carriers for the capture port control registers
// Assumes: one clock, indexed register port in the same domain
// Notes:   all register indices, fields and reset values live here
`default_nettype none
package vcp_pkg;
  ////////////////////////////////////////////////////////////////////////
  localparam logic [7:0] IDX_ADDR_HI  = 8'h59;
  localparam logic [7:0] IDX_CYC_CTL  = 8'h5a;
  localparam logic [7:0] IDX_LUMA_OFS = 8'h5b;
  localparam logic [7:0] IDX_PIN_CTL  = 8'h5c;
  localparam logic [7:0] REG_RESET    = 8'h00;
  localparam int         NUM_REGS     = 4;

  localparam logic [1:0] SLOT_ADDR_HI  = 2'h0;
  localparam logic [1:0] SLOT_CYC_CTL  = 2'h1;
  localparam logic [1:0] SLOT_LUMA_OFS = 2'h2;
  localparam logic [1:0] SLOT_PIN_CTL  = 2'h3;

  // cycle control register fields
  localparam int VW_MISS_LSB  = 6;
  localparam int CRT_MISS_LSB = 4;
  localparam int UNDERRUN_BIT = 3;
  localparam int GFX_THR_LSB  = 0;
  localparam int GFX_THR_W    = 3;
  localparam int MISS_W       = 2;

  // pin control register fields
  localparam int PIN_OUT_BIT   = 7;
  localparam int ODD_ONLY_BIT  = 6;
  localparam int TWO_FIELD_BIT = 5;
  localparam int RS_EN_BIT     = 4;
  localparam int RS_THR_LSB    = 0;
  localparam int RS_THR_W      = 4;

  localparam int ADDR_W    = 19;
  localparam int ADDR_LO_W = 11;
  localparam logic [1:0] TWO_FIELD_EDGES = 2'h3;
  localparam logic [1:0] MISS_SKIP       = 2'h0;
  localparam logic [7:0] LUMA_MAX        = 8'hff;

  ////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    logic vw_miss;
    logic crt_miss;
    logic underrun;
    logic win_end;
  } vcp_mem_evt_t;

  typedef struct packed {
    logic       valid;
    logic       in_win;
    logic [7:0] luma;
  } vcp_pix_t;

  typedef struct packed {
    logic                  valid;
    logic [MISS_W-1:0]     len;
  } vcp_burst_t;

  typedef struct packed {
    logic                  valid;
    logic [RS_THR_W-1:0]   total;
  } vcp_limit_t;
endpackage : vcp_pkg
`default_nettype wire

// >>> verif/vcp_decoder_model.sv
// Purpose: behavioural video decoder that drives the capture port sync pins
// Assumes: sync pins are sampled asynchronously by the port
// Notes:   frames only on request; both syncs idle low between frames
`default_nettype none
module vcp_decoder_model (
  // clock used only to pace the frame
  input  wire logic clk,
  // sync pins
  output var  logic vsync,
  output var  logic href
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    vsync = 1'b0;
    href  = 1'b0;
  end

  //////////////////////////////////////////////////////////////////////////
  // odd field: href high across the vsync fall
  task automatic frame(input logic odd);
    // an edge between frames so href never falls and rises in one step
    @(negedge clk);
    href = odd;
    @(negedge clk);
    vsync = 1'b1;
    repeat (4) @(negedge clk);
    vsync = 1'b0;
    // hold href well past the port's synchroniser delay
    repeat (8) @(negedge clk);
    href = 1'b0;
  endtask
endmodule // vcp_decoder_model
`default_nettype wire

// >>> verif/video_capture_port_control_regs_tb.sv
// Purpose: self-checking bench for the capture port control registers
// Assumes: inputs change on the falling clock edge
// Notes:   in odd-only mode field capture expects href level at vsync fall xor invert
`default_nettype none
module video_capture_port_control_regs_tb;
  timeunit 1ns;
  timeprecision 1ps;

  logic                  clk, clk_en, rstn, io_wr, io_rd, seq_cfg, oe_inv, vsync, href, pin, pin_oe, fcap;
  logic [7:0]            io_idx, io_wdata, io_rdata_q;
  logic [10:0]           addr_lo;
  logic [2:0]            gfx;
  logic [18:0]           act;
  vcp_pkg::vcp_mem_evt_t mem_evt;
  vcp_pkg::vcp_burst_t   burst;
  vcp_pkg::vcp_limit_t   lim;
  vcp_pkg::vcp_pix_t     pix_in, pix_out;
  int                    n_fail, n_compared;

  vcp_regs i_vcp_regs (.clk(clk), .rstn(rstn), .clk_en(clk_en), .io_idx(io_idx), .io_wr(io_wr),
    .io_rd(io_rd), .io_wdata(io_wdata), .io_rdata_q(io_rdata_q), .start_addr_low(addr_lo),
    .sequencer_ext_config(seq_cfg), .odd_even_invert(oe_inv), .port_vsync(vsync), .port_href(href),
    .capture_sync_control_pin_q(pin), .capture_sync_control_pin_oe_q(pin_oe), .mem_evt(mem_evt),
    .port_burst_q(burst), .win_end_limit_q(lim), .gfx_cas_per_cycle_q(gfx), .active_addr_q(act),
    .field_capture_q(fcap), .pix_in(pix_in), .pix_out_q(pix_out));

  vcp_decoder_model i_vcp_decoder_model (.clk(clk), .vsync(vsync), .href(href));

  initial clk = 1'b0;
  always #5 clk = ~clk;

  //////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask

  // each request first lets an edge pass, so a strobe never drops and rises in one step
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    cyc(1);
    io_idx   = idx;
    io_wdata = d;
    io_wr    = 1'b1;
    cyc(1);
    io_wr    = 1'b0;
  endtask

  task automatic rdc(input logic [7:0] idx, input logic [7:0] exp);
    cyc(1);
    io_idx = idx;
    io_rd  = 1'b1;
    cyc(1);
    io_rd  = 1'b0;
    chk(io_rdata_q, exp);
  endtask

  // one-cycle event pulse; registered answers are settled on return
  task automatic ev(input vcp_pkg::vcp_mem_evt_t e);
    cyc(1);
    mem_evt = e;
    cyc(1);
    mem_evt = '0;
  endtask

  task automatic px(input logic w, input logic [7:0] l, input logic [7:0] e);
    pix_in = {1'b1, w, l};
    cyc(1);
    chk(pix_out, {1'b1, w, e});
  endtask

  task automatic report_and_stop();
    $display("compared %0d, failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  //////////////////////////////////////////////////////////////////////////
  initial begin
    {rstn, io_wr, io_rd, seq_cfg, oe_inv, io_idx, io_wdata, addr_lo} = '0;
    mem_evt = '0;
    clk_en  = 1'b1;
    pix_in  = '0;
    n_fail  = 0;
    n_compared = 0;
    repeat (20) @(negedge clk);
    rstn = 1'b1;
    cyc(1);
    for (int i = 0; i < 4; i++) rdc(8'(8'h59 + i), 8'h00);
    wr(8'h5b, 8'h3c);
    rdc(8'h5b, 8'h3c);
    rdc(8'h5d, 8'h3c);
    wr(8'h5a, 8'hff);
    rdc(8'h5a, 8'hf7);
    cyc(2);
    chk(gfx, 3'h7);
    for (int c = 0; c < 4; c++) begin
      wr(8'h5a, {c[1:0], ~c[1:0], 4'h5});
      ev(4'h8);
      chk(burst, {c != 0, c[1:0]});
      ev(4'h4);
      chk(burst, {c != 3, ~c[1:0]});
    end
    ev(4'h2);
    rdc(8'h5a, 8'hcd);
    rdc(8'h5a, 8'hc5);
    wr(8'h5b, 8'h0a);
    px(1'b1, 8'h20, 8'h2a);
    px(1'b0, 8'h20, 8'h20);
    px(1'b1, 8'hfa, 8'hff);
    wr(8'h5b, 8'hf6);
    px(1'b1, 8'h05, 8'h00);
    px(1'b1, 8'h20, 8'h16);
    // enable low freezes all state: the write must not land
    clk_en = 1'b0;
    wr(8'h5b, 8'h55);
    clk_en = 1'b1;
    rdc(8'h5b, 8'hf6);
    wr(8'h5c, 8'h17);
    ev(4'h1);
    chk(lim, 5'h17);
    wr(8'h5c, 8'h07);
    ev(4'h1);
    chk(lim, 5'h00);
    // start address and pin wait for the next retrace
    addr_lo = 11'h123;
    wr(8'h59, 8'ha5);
    wr(8'h5c, 8'h80);
    cyc(8);
    chk(act, 19'h0);
    chk(pin, 1'b0);
    chk(pin_oe, 1'b1);
    i_vcp_decoder_model.frame(1'b1);
    chk(act, {8'ha5, 11'h123});
    chk(pin, 1'b1);
    addr_lo = 11'h7ff;
    cyc(2);
    chk(act, {8'ha5, 11'h123});
    seq_cfg = 1'b1;
    cyc(2);
    chk(pin_oe, 1'b0);
    seq_cfg = 1'b0;
    wr(8'h5c, 8'h40);
    for (int k = 0; k < 4; k++) begin
      oe_inv = k[1];
      i_vcp_decoder_model.frame(k[0]);
      chk(fcap, k[0] ^ k[1]);
    end
    oe_inv = 1'b0;
    wr(8'h5c, 8'h00);
    i_vcp_decoder_model.frame(1'b0);
    chk(fcap, 1'b1);
    wr(8'h5c, 8'h20);
    i_vcp_decoder_model.frame(1'b1);
    i_vcp_decoder_model.frame(1'b0);
    rdc(8'h5c, 8'h20);
    chk(fcap, 1'b1);
    i_vcp_decoder_model.frame(1'b1);
    rdc(8'h5c, 8'h00);
    chk(fcap, 1'b0);
    report_and_stop();
  end

  // tests need well under a thousand cycles
  initial begin
    repeat (5000) @(posedge clk);
    n_fail++;
    report_and_stop();
  end
endmodule // video_capture_port_control_regs_tb
`default_nettype wire
